// >>> hw/tot_ts_path.sv
// timestamp action path for one direction: analyzer, stamp stage,
// rewriter with fcs regeneration, and the tx stamp fifo on egress
// assumes contiguous frames, one byte per clock, no preamble, frames
// of at least 64 bytes, class and pdu offset valid with the first byte
`timescale 1ns/1ns

module tot_ts_path
    import tot_pkg::*;
#(
    parameter bit IS_EGRESS  = 1'b0,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    input  wire tot_byte_t   rx_i,
    input  wire tot_cls_t    cls_i,
    input  wire logic [10:0] pdu_off_i,
    input  wire logic        mpls_tp_i,
    input  wire logic [7:0]  domain_cfg_i,
    input  wire logic [31:0] ts_sec_i,
    input  wire logic [31:0] ts_ns_i,
    input  wire logic [31:0] local_adj_i,
    input  wire logic [31:0] asym_i,
    output tot_byte_t        tx_o,
    output logic             ts_save_o,
    input  wire logic        fifo_pop_i,
    output tot_fifo_ent_t    fifo_ent_o,
    output logic             fifo_valid_o,
    output logic             fifo_ovf_o
);

    // ==========================================================
    // analyzer decision table
    function automatic tot_plan_t plan_of(input tot_cls_t c,
                                          input logic     mpls,
                                          input logic     egr);
        tot_plan_t   p;
        logic [10:0] s0;
        p  = '{act: ACT_NONE, is_ptp: 1'b0, off: '0, sz: '0,
               neg: 1'b0, cf_add: 1'b0, clr_res: 1'b0};
        s0 = mpls ? MPLS_TS_BASE : OAM_TS_BASE;
        unique case (c)
            CLS_NONE: begin
                p.act = ACT_NONE;
            end
            CLS_SYNC, CLS_DREQ: begin
                p.is_ptp = 1'b1;
                if (egr) begin
                    p.act     = ACT_WRITE_SAVE;
                    p.clr_res = 1'b1;
                end else begin
                    p.act    = ACT_WRITE;
                    p.off    = PTP_RES_OFF;
                    p.sz     = PTP_RES_SZ;
                    p.neg    = 1'b1;
                    p.cf_add = (c == CLS_SYNC);
                end
            end
            CLS_1DM, CLS_DMM: begin
                p.act = ACT_WRITE;
                p.sz  = SLOT_SZ;
                p.neg = !egr;
                p.off = s0 + (egr ? SLOT_TXF : SLOT_RXF);
            end
            CLS_DMR: begin
                p.act = ACT_WRITE;
                p.sz  = SLOT_SZ;
                p.neg = !egr;
                p.off = s0 + (egr ? SLOT_TXB : SLOT_RXB);
            end
        endcase
        return p;
    endfunction : plan_of

    // ==========================================================
    // stamp arithmetic with nanosecond wrap into seconds
    function automatic logic [63:0] ts_adjust(input logic [63:0] ts,
                                              input logic [31:0] d,
                                              input logic        neg);
        logic signed [33:0] ns;
        logic signed [33:0] dd;
        logic [31:0]        sec;
        dd  = $signed({{2{d[31]}}, d});
        ns  = $signed({2'b00, ts[31:0]}) + (neg ? -dd : dd);
        sec = ts[63:32];
        if (ns < 0) begin
            ns  = ns + NS_PER_SEC;
            sec = sec - 32'h00000001;
        end else if (ns >= NS_PER_SEC) begin
            ns  = ns - NS_PER_SEC;
            sec = sec + 32'h00000001;
        end
        return {sec, ns[31:0]};
    endfunction : ts_adjust

    // ==========================================================
    // declarations
    tot_byte_t     line_reg [DLY_BYTES];
    tot_byte_t     cur;
    tot_byte_t     tx_reg;
    tot_ctx_t      in_ctx_reg;
    tot_ctx_t      ctx_reg;
    tot_plan_t     plan;
    logic [10:0]   pos;
    logic [10:0]   pos_reg;
    logic [10:0]   st_off;
    logic [10:0]   st_rel;
    logic [10:0]   cf_off;
    logic [10:0]   cf_rel;
    logic [10:0]   res_off;
    logic [10:0]   res_rel;
    logic [10:0]   dom_off;
    logic [10:0]   seq_off;
    logic          dom_ok_reg;
    logic [7:0]    dom_byte_reg;
    logic [15:0]   seq_reg;
    logic [31:0]   res_reg;
    logic [63:0]   cf_raw;
    logic [63:0]   asym_cf;
    logic [63:0]   cf_sum_reg;
    logic [63:0]   stamp;
    logic [63:0]   fifo_ts;
    logic          active;
    logic          in_st;
    logic          in_cf;
    logic          in_clr;
    logic          in_fcs;
    logic [1:0]    fcs_idx;
    logic [3:0]    st_idx;
    logic [7:0]    st_byte;
    logic [7:0]    out_byte;
    logic [31:0]   crc_reg;
    logic [31:0]   crc_in;
    logic [31:0]   crc_next;
    logic          push;
    logic          fifo_full;
    tot_fifo_ent_t push_ent;
    logic          save_reg;
    logic          ovf_reg;

    // ==========================================================
    // input side: stamp taken at start of frame
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            in_ctx_reg <= '0;
        end else if (rx_i.valid && rx_i.sof) begin
            in_ctx_reg <= '{cls: cls_i, mpls: mpls_tp_i, base: pdu_off_i,
                            ts: {ts_sec_i, ts_ns_i}};
        end
    end

    // delay line gives the rewriter its decision before the field passes
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int k = 0; k < DLY_BYTES; k++) begin
                line_reg[k] <= '0;
            end
        end else begin
            for (int k = 0; k < DLY_BYTES - 1; k++) begin
                line_reg[k] <= line_reg[k+1];
            end
            line_reg[DLY_BYTES-1] <= rx_i;
        end
    end

    assign cur = line_reg[0];

    // frames outlast the line, so the next start cannot clobber this
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctx_reg <= '0;
        end else if (cur.valid && cur.sof) begin
            ctx_reg <= in_ctx_reg;
        end
    end

    assign pos = cur.sof ? 11'h000 : pos_reg;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pos_reg <= '0;
        end else if (cur.valid) begin
            pos_reg <= pos + 11'h001;
        end
    end

    // ==========================================================
    // analyzer: plan, domain check and header captures
    assign plan    = plan_of(ctx_reg.cls, ctx_reg.mpls, IS_EGRESS);
    assign dom_off = ctx_reg.base + PTP_DOM_OFF;
    assign cf_off  = ctx_reg.base + PTP_CF_OFF;
    assign res_off = ctx_reg.base + PTP_RES_OFF;
    assign seq_off = ctx_reg.base + PTP_SEQ_OFF;
    assign active  = (plan.act != ACT_NONE) && (!plan.is_ptp || dom_ok_reg);

    // taps one ahead of the output byte hold the next eight bytes
    always_comb begin
        cf_raw = '0;
        for (int k = 1; k <= 8; k++) begin
            cf_raw = {cf_raw[55:0], line_reg[k].data};
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dom_ok_reg   <= 1'b0;
            dom_byte_reg <= '0;
        end else if (cur.valid && cur.sof) begin
            dom_ok_reg <= 1'b0;
        end else if (cur.valid && pos == dom_off - 11'h001) begin
            dom_ok_reg   <= (line_reg[1].data == domain_cfg_i);
            dom_byte_reg <= line_reg[1].data;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seq_reg <= '0;
            res_reg <= '0;
        end else begin
            if (cur.valid && pos == seq_off - 11'h001) begin
                seq_reg <= cf_raw[63:48];
            end
            if (cur.valid && pos == res_off - 11'h001) begin
                res_reg <= cf_raw[63:32];
            end
        end
    end

    // ==========================================================
    // timestamp stage
    assign stamp   = ts_adjust(ctx_reg.ts, local_adj_i, plan.neg);
    assign fifo_ts = (ctx_reg.cls == CLS_DREQ) ? ts_adjust(stamp, asym_i, 1'b1) : stamp;
    // correction field counts in 2^-16 ns
    assign asym_cf = {{16{asym_i[31]}}, asym_i, 16'h0000};

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cf_sum_reg <= '0;
        end else if (cur.valid && plan.cf_add && pos == cf_off - 11'h001) begin
            cf_sum_reg <= cf_raw + asym_cf;
        end
    end

    // ==========================================================
    // rewriter field windows
    assign st_rel  = pos - st_off;
    assign st_off  = ctx_reg.base + plan.off;
    assign cf_rel  = pos - cf_off;
    assign res_rel = pos - res_off;
    assign in_st   = active && (st_rel < {7'h00, plan.sz});
    assign in_cf   = active && plan.cf_add && (cf_rel < {7'h00, CF_SZ});
    assign in_clr  = active && plan.clr_res && (res_rel < {7'h00, PTP_RES_SZ});
    assign st_idx  = plan.sz - 4'h1 - st_rel[3:0];
    assign st_byte = stamp[{st_idx[2:0], 3'b000} +: 8];

    // last four bytes of a contiguous frame are the fcs
    always_comb begin
        in_fcs  = cur.valid;
        fcs_idx = 2'h3;
        if (cur.eof) begin
            fcs_idx = 2'h3;
        end else if (line_reg[1].eof) begin
            fcs_idx = 2'h2;
        end else if (line_reg[2].eof) begin
            fcs_idx = 2'h1;
        end else if (line_reg[3].eof) begin
            fcs_idx = 2'h0;
        end else begin
            in_fcs = 1'b0;
        end
    end

    always_comb begin
        out_byte = cur.data;
        if (in_fcs && active) begin
            out_byte = ~crc_reg[{fcs_idx, 3'b000} +: 8];
        end else if (in_st) begin
            out_byte = st_byte;
        end else if (in_clr) begin
            out_byte = 8'h00;
        end else if (in_cf) begin
            out_byte = cf_sum_reg[{3'h7 - cf_rel[2:0], 3'b000} +: 8];
        end
    end

    // crc runs over the rewritten bytes and freezes over the fcs
    assign crc_in = cur.sof ? CRC_INIT : crc_reg;

    tot_crc_byte u_crc (
        .crc_i  (crc_in),
        .data_i (out_byte),
        .crc_o  (crc_next)
    );

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            crc_reg <= CRC_INIT;
        end else if (cur.valid && !in_fcs) begin
            crc_reg <= crc_next;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_reg <= '0;
        end else begin
            tx_reg <= '{valid: cur.valid, sof: cur.sof, eof: cur.eof, data: out_byte};
        end
    end

    assign tx_o = tx_reg;

    // ==========================================================
    // tx stamp fifo, pushed as the last byte leaves
    assign push     = cur.valid && cur.eof && active && (plan.act == ACT_WRITE_SAVE);
    assign push_ent = '{ts_ns: fifo_ts[31:0],
                        frame_id: {seq_reg, res_reg, dom_byte_reg, 24'h000000}};

    tot_ts_fifo #(
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .push_i  (push),
        .ent_i   (push_ent),
        .pop_i   (fifo_pop_i),
        .ent_o   (fifo_ent_o),
        .valid_o (fifo_valid_o),
        .full_o  (fifo_full)
    );

    // a full fifo drops the set; software sees it only through the pulse
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            save_reg <= 1'b0;
            ovf_reg  <= 1'b0;
        end else begin
            save_reg <= push;
            ovf_reg  <= push && fifo_full;
        end
    end

    assign ts_save_o  = save_reg;
    assign fifo_ovf_o = ovf_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    chk_latency_fixed: assert property (rx_i.valid |-> ##17 tx_o.valid)
        else $error("stream latency not seventeen cycles");

    chk_pass_through: assert property (cur.valid && !active |=> tx_o.data == $past(cur.data))
        else $error("unmatched byte altered");

    chk_ptp_res_ns: assert property (in_st && st_rel == 11'h000 && plan.sz == PTP_RES_SZ
        |=> tx_o.data == $past(stamp[31:24]) ##3 tx_o.data == $past(stamp[7:0], 4))
        else $error("reserved bytes not the adjusted nanoseconds");

    chk_oam_slot: assert property (in_st && st_rel == 11'h000 && plan.sz == SLOT_SZ
        |=> tx_o.data == $past(stamp[63:56]) ##1 tx_o.data == $past(stamp[55:48], 2))
        else $error("oam slot not written with stamp");

    chk_res_clear: assert property (in_clr |=> tx_o.data == 8'h00)
        else $error("reserved bytes not cleared on egress");

    chk_zero_size: assert property (plan.act == ACT_WRITE_SAVE |-> plan.sz == 4'h0 && plan.clr_res)
        else $error("write+save with nonzero write size");

    chk_cf_asym: assert property (cur.valid && plan.cf_add && pos == cf_off - 11'h001
        |=> cf_sum_reg == $past(cf_raw) + $past(asym_cf))
        else $error("correction field not raised by asymmetry");

    chk_save_pulse: assert property (push |=> ts_save_o && fifo_valid_o)
        else $error("save flag or fifo entry missing");

    chk_save_cause: assert property (ts_save_o |-> IS_EGRESS && $past(active))
        else $error("stamp saved for unmatched frame");

    chk_sync_fifo: assert property (push && ctx_reg.cls == CLS_SYNC
        |-> push_ent.ts_ns == stamp[31:0] && !plan.neg)
        else $error("sync fifo value not ns plus adjust");

    chk_oam_sign: assert property (plan.act == ACT_WRITE && !plan.is_ptp
        |-> plan.neg == !IS_EGRESS)
        else $error("oam adjust sign wrong for direction");

endmodule : tot_ts_path

// >>> shared/tot_pkg.sv
// constants and carrier types for the two-step tc / oam timestamp path
// assumes a byte-wide frame stream, one byte per clock inside a frame
package tot_pkg;

    // ==========================================================
    // stream and delay line
    localparam int          DLY_BYTES    = 16;
    localparam int          POS_W        = 11;

    // ==========================================================
    // ptp header field offsets, relative to the ptp header start
    localparam logic [10:0] PTP_DOM_OFF  = 11'h004;
    localparam logic [10:0] PTP_CF_OFF   = 11'h008;
    localparam logic [10:0] PTP_RES_OFF  = 11'h010;
    localparam logic [10:0] PTP_SEQ_OFF  = 11'h01E;
    localparam logic [3:0]  PTP_RES_SZ   = 4'h4;
    localparam logic [3:0]  CF_SZ        = 4'h8;

    // ==========================================================
    // delay-measurement slots: ethernet oam after the 4-byte common
    // header, mpls-tp after the 4-byte ach and 8-byte pdu header
    localparam logic [3:0]  SLOT_SZ      = 4'h8;
    localparam logic [10:0] OAM_TS_BASE  = 11'h004;
    localparam logic [10:0] MPLS_TS_BASE = 11'h00C;
    localparam logic [10:0] SLOT_TXF     = 11'h000;
    localparam logic [10:0] SLOT_RXF     = 11'h008;
    localparam logic [10:0] SLOT_TXB     = 11'h010;
    localparam logic [10:0] SLOT_RXB     = 11'h018;

    // ==========================================================
    // stamp arithmetic and fcs
    localparam logic signed [33:0] NS_PER_SEC = 34'sh3B9ACA00;
    localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY     = 32'hEDB88320;
    localparam int          ID_W         = 80;

    // ==========================================================
    // carrier types
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } tot_byte_t;

    typedef enum logic [2:0] {
        CLS_NONE, CLS_SYNC, CLS_DREQ, CLS_1DM, CLS_DMM, CLS_DMR
    } tot_cls_t;

    typedef enum logic [1:0] {ACT_NONE, ACT_WRITE, ACT_WRITE_SAVE} tot_act_t;

    typedef struct packed {
        tot_act_t    act;
        logic        is_ptp;
        logic [10:0] off;
        logic [3:0]  sz;
        logic        neg;
        logic        cf_add;
        logic        clr_res;
    } tot_plan_t;

    typedef struct packed {
        tot_cls_t    cls;
        logic        mpls;
        logic [10:0] base;
        logic [63:0] ts;
    } tot_ctx_t;

    typedef struct packed {
        logic [31:0]     ts_ns;
        logic [ID_W-1:0] frame_id;
    } tot_fifo_ent_t;

endpackage : tot_pkg

// >>> hw/tot_crc_byte.sv
// one byte step of the reflected ethernet crc32
// assumes the caller holds the running value and picks the seed
`timescale 1ns/1ns

module tot_crc_byte
    import tot_pkg::*;
(
    input  wire logic [31:0] crc_i,
    input  wire logic [7:0]  data_i,
    output logic      [31:0] crc_o
);

    // ==========================================================
    // bitwise lfsr, lsb first
    always_comb begin
        logic [31:0] c;
        c = crc_i;
        for (int b = 0; b < 8; b++) begin
            if (c[0] ^ data_i[b]) begin
                c = (c >> 1) ^ CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        crc_o = c;
    end

endmodule : tot_crc_byte

// >>> hw/tot_ts_fifo.sv
// tx timestamp fifo: stamp plus frame identifier sets for software
// assumes one push per frame at most, pop from the reading side
`timescale 1ns/1ns

module tot_ts_fifo
    import tot_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          clock_i,
    input  wire logic          nrst_i,
    input  wire logic          push_i,
    input  wire tot_fifo_ent_t ent_i,
    input  wire logic          pop_i,
    output tot_fifo_ent_t      ent_o,
    output logic               valid_o,
    output logic               full_o
);

    tot_fifo_ent_t mem [DEPTH];
    logic [AW:0]   wr_reg;
    logic [AW:0]   rd_reg;

    // ==========================================================
    // pointers carry a wrap bit so full and empty stay distinct
    assign full_o  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    assign valid_o = (wr_reg != rd_reg);
    assign ent_o   = mem[rd_reg[AW-1:0]];

    always_ff @(posedge clock_i) begin
        if (push_i && !full_o) begin
            mem[wr_reg[AW-1:0]] <= ent_i;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push_i && !full_o) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop_i && valid_o) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end

endmodule : tot_ts_fifo

// >>> test/tot_mac_src.sv
// frame source standing in for the mac datapath feeding the path
// assumes the bench fills buf_q and calls send at a falling edge
`timescale 1ns/1ns

module tot_mac_src
    import tot_pkg::*;
(
    input  wire logic clock_i,
    output tot_byte_t rx_o
);
    logic [7:0] buf_q [0:79];

    initial rx_o = '0;

    // ==========================================================
    // contiguous frame, one byte a clock, no back-pressure
    task automatic send(input int len);
        for (int i = 0; i < len; i++) begin
            rx_o <= {1'b1, i == 0, i == len - 1, buf_q[i]};
            @(negedge clock_i);
        end
        // idle data inverted so a stale byte never looks valid
        rx_o <= {3'b000, ~buf_q[len - 1]};
    endtask : send
endmodule : tot_mac_src

// >>> test/testbench.sv
// self-checking bench, ingress and egress paths fed the same frames
// assumes 64-byte frames, pdu at byte 14, a two-entry tx fifo
`timescale 1ns/1ns

module testbench;
    import tot_pkg::*;
    logic          clock_i = 1'b0;
    logic          nrst_i  = 1'b0;
    tot_byte_t     rx;
    tot_cls_t      cls     = CLS_NONE;
    logic          mpls    = 1'b0;
    logic [7:0]    dom     = 8'h05;
    logic [31:0]   sec     = 32'h00000007;
    logic [31:0]   ns      = 32'h00000064;
    logic [31:0]   adj     = 32'h0000012C;
    logic [31:0]   asym    = 32'hFFFFFFFE;
    logic [1:0]    pop     = 2'h0;
    logic [1:0]    save, fvld, ovf;
    tot_byte_t     tx [2];
    tot_fifo_ent_t ent [2];
    logic [7:0]    cap [3][0:79];
    int            n_cap [2];
    int            n_save [2];
    int            n_ovf, n_errors, samples_checked;

    always #4 clock_i = ~clock_i;

    tot_mac_src src_u (.clock_i(clock_i), .rx_o(rx));

    for (genvar g = 0; g < 2; g++) begin : gen_dir
        tot_ts_path #(.IS_EGRESS(g == 1), .FIFO_DEPTH(2)) dut_u (
            .clock_i(clock_i), .nrst_i(nrst_i), .rx_i(rx), .cls_i(cls),
            .pdu_off_i(11'h00E), .mpls_tp_i(mpls), .domain_cfg_i(dom),
            .ts_sec_i(sec), .ts_ns_i(ns), .local_adj_i(adj), .asym_i(asym),
            .tx_o(tx[g]), .ts_save_o(save[g]), .fifo_pop_i(pop[g]),
            .fifo_ent_o(ent[g]), .fifo_valid_o(fvld[g]), .fifo_ovf_o(ovf[g]));
    end

    // ==========================================================
    // output capture
    always @(posedge clock_i) begin
        for (int g = 0; g < 2; g++) begin
            if (tx[g].valid === 1'b1) begin
                if (tx[g].sof === 1'b1) n_cap[g] = 0;
                cap[g][n_cap[g]] = tx[g].data;
                n_cap[g]++;
            end
            if (save[g] === 1'b1) n_save[g]++;
        end
        if (ovf[1] === 1'b1) n_ovf++;
    end

    // ==========================================================
    // helpers
    task automatic chk(input logic [79:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [63:0] fld(input int g, off, sz);
        fld = '0;
        for (int i = 0; i < sz; i++) fld = {fld[55:0], cap[g][off + i]};
    endfunction : fld

    function automatic logic [63:0] stamp(input longint d);
        longint t;
        t = longint'(sec) * 1000000000 + longint'(ns) + d;
        return {32'(t / 1000000000), 32'(t % 1000000000)};
    endfunction : stamp

    // residue check covers the whole frame without rebuilding the fcs
    function automatic logic [31:0] crc_res(input int g);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < 64; i++) begin
            c = c ^ 32'(cap[g][i]);
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        end
        return c;
    endfunction : crc_res

    task automatic run(input tot_cls_t c, input logic m, input int s);
        for (int i = 0; i < 80; i++) src_u.buf_q[i] = 8'(i * 37 + 11);
        src_u.buf_q[18] = 8'h05;
        for (int i = s; i < s + 32 && i < 80; i++) src_u.buf_q[i] = 8'h00;
        // reply frames carry swapped addresses, as the responder builds them
        for (int i = 0; i < 6 && c == CLS_DMR; i++) begin
            {src_u.buf_q[i], src_u.buf_q[i + 6]} = {src_u.buf_q[i + 6], src_u.buf_q[i]};
        end
        cap[2] = src_u.buf_q;
        cls = c;
        mpls = m;
        src_u.send(64);
        repeat (24) @(negedge clock_i);
    endtask : run

    // ==========================================================
    // scenarios
    task automatic s_ptp(input tot_cls_t c);
        logic [63:0] cf;
        int sv;
        sv = n_save[1];
        run(c, 1'b0, 80);
        cf = fld(2, 22, 8) + ((c == CLS_SYNC) ? (longint'($signed(asym)) <<< 16) : 0);
        chk(fld(0, 30, 4), 32'(stamp(-longint'(adj))), "rx reserved");
        chk(fld(0, 22, 8), cf, "rx correction");
        chk(crc_res(0), 32'hDEBB20E3, "rx fcs");
        chk(fld(1, 30, 4), '0, "tx reserved");
        chk(fld(1, 22, 8), fld(2, 22, 8), "tx correction");
        chk(n_save[1] - sv + fvld[1], 2, "save and fifo");
        chk(ent[1].ts_ns, 32'(stamp(longint'(adj)
            - ((c == CLS_DREQ) ? longint'($signed(asym)) : 0))), "fifo stamp");
        chk(ent[1].frame_id, {16'(fld(2, 44, 2)), 32'(fld(2, 30, 4)), 32'h05000000},
            "frame id");
        pop = 2'b10;
        @(negedge clock_i);
        pop = 2'h0;
    endtask : s_ptp

    task automatic s_oam();
        tot_cls_t c;
        int s, o;
        for (int k = 0; k < 6; k++) begin
            c = (k % 3 == 0) ? CLS_1DM : (k % 3 == 1) ? CLS_DMM : CLS_DMR;
            s = (k < 3) ? 18 : 26;
            o = (c == CLS_DMR) ? 16 : 0;
            run(c, k >= 3, s);
            chk(fld(0, s + o + 8, 8), stamp(-longint'(adj)), "rx slot");
            chk(fld(1, s + o, 8), stamp(longint'(adj)), "tx slot");
            chk({crc_res(0), crc_res(1)}, {2{32'hDEBB20E3}}, "oam fcs");
        end
    endtask : s_oam

    task automatic s_pass();
        int sv;
        sv = n_save[1];
        for (int k = 0; k < 2; k++) begin
            dom = (k == 0) ? 8'h06 : 8'h05;
            run((k == 0) ? CLS_SYNC : CLS_NONE, 1'b0, 80);
            for (int i = 0; i < 128; i++) chk(cap[i / 64][i % 64], cap[2][i % 64], "pass");
        end
        chk(n_save[1] - sv + n_save[0] + fvld[1], 0, "nothing saved");
    endtask : s_pass

    task automatic s_ovf();
        for (int k = 0; k < 3; k++) run(CLS_SYNC, 1'b0, 80);
        chk(n_ovf, 1, "overflow");
        pop = 2'b10;
        repeat (2) @(negedge clock_i);
        pop = 2'h0;
        @(negedge clock_i);
        chk(fvld[1], 0, "drained");
    endtask : s_ovf

    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (16) @(negedge clock_i);
        nrst_i = 1'b1;
        chk({tx[0], tx[1], save, fvld}, '0, "after reset");
        s_ptp(CLS_SYNC);
        s_ptp(CLS_DREQ);
        s_oam();
        s_pass();
        s_ovf();
        print_verdict();
    end
endmodule : testbench
